// [rtl/mrtu_params.svh]
// Constants for the multi-register transfer unit: offsets, field positions,
// reset values and address checks. Definitions only; included by name.
`ifndef MRTU_PARAMS_SVH
`define MRTU_PARAMS_SVH
// Byte offsets and address region codes on the register bus
`define MRTU_OFS_INSTR   8'h00
`define MRTU_OFS_STATUS  8'h04
`define MRTU_REGION_CUR  2'h1
`define MRTU_REGION_USR  2'h2
// Instruction word fields
`define MRTU_F_BASE_LO   16
`define MRTU_F_LOAD      20
`define MRTU_F_WBACK     21
`define MRTU_F_SBIT      22
`define MRTU_F_UP        23
`define MRTU_F_PRE       24
// Status word bits
`define MRTU_ST_BUSY     0
`define MRTU_ST_AEXC     1
`define MRTU_ST_DABT     2
// Program counter and status fields of register fifteen
`define MRTU_PC_ADVANCE  24'h00_0003
`define MRTU_MODE_USER   2'h0
`define MRTU_PC_IDX      4'hf
`define MRTU_R15_RESET   32'h0c00_0003
`define MRTU_ADDR_CHK_HI 31
`define MRTU_ADDR_CHK_LO 26
`endif

// [rtl/mrtu_pkg.sv]
// Types shared by the multi-register transfer unit.
// Assumes the constants header is compiled alongside.
package mrtu_pkg;
    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SETUP = 2'b01,
        ST_XFER  = 2'b10,
        ST_DONE  = 2'b11
    } mrtu_state_type;
endpackage

// [rtl/mrtu_top.sv]
// Multi-register transfer unit: register banks, block load/store sequencer,
// memory transfer port and Avalon-MM register slave.
// Assumes memory and abort logic run on clk_i and answer with mem_ack_i.
`timescale 1ns/1ps
`include "mrtu_params.svh"

// Summary of operation
// - Sixteen-bit list, bit n moves register n
// - Addresses from base, pre/post and up/down
// - Ascending order, lowest register lowest address
// - Stored counter is status plus counter twelve ahead
// - Loaded counter; status kept or loaded per S
// - User start protects interrupt and mode bits
// - Privileged store with S uses user bank
// - Privileged load with S, no counter: user bank
// - Counter base includes status, never written back
// - Base written after second cycle, first store earlier
// - Loaded base replaces written-back base
// - Bad first address: no writes, address trap
// - Only first address checked; later ones wrap
// - Abort accepted on any transfer, recoverable
// - Store abort: finish, trap, only write-back changes
// - Load abort drops aborted, immediately preceding and later loads
// - Load abort restores modified base, then trap
// - Mode bits on address low bits
// - No write-back keeps base unless loaded
// - Four variants from pre and up bits
module mrtu_top
    import mrtu_pkg::*;
(
    input  wire logic        clk_i,             // 250 MHz clock
    input  wire logic        rst_n_i,           // Async reset, active low
    input  wire logic [7:0]  av_address_i,      // Byte address
    input  wire logic        av_read_i,         // Read request
    input  wire logic        av_write_i,        // Write request
    input  wire logic [31:0] av_writedata_i,    // Write data
    input  wire logic [3:0]  av_byteenable_i,   // Byte lanes
    output logic      [31:0] av_readdata_o,     // Read data
    output logic             av_waitrequest_o,  // Stall
    output logic             mem_req_o,         // Transfer request
    output logic             mem_we_o,          // Store when high
    output logic      [25:0] mem_addr_o,        // Word address, mode in [1:0]
    output logic      [31:0] mem_wdata_o,       // Store data
    input  wire logic [31:0] mem_rdata_i,       // Load data
    input  wire logic        mem_ack_i,         // Transfer done
    input  wire logic        abort_input_i,     // Abort with ack
    output logic             addr_exc_trap_o,   // Address trap pulse
    output logic             data_abort_trap_o  // Data abort trap pulse
);
    logic [1:0]     rst_sync_reg;
    logic           rst_n;
    logic [31:0]    usr_reg [0:14];
    logic [31:0]    prv_reg [0:14];
    logic [31:0]    r15_reg;
    logic [31:0]    instr_reg;
    logic [2:0]     status_reg;
    mrtu_state_type state_reg;
    logic [15:0]    list_reg;
    logic [3:0]     cur_reg;
    logic [3:0]     base_reg;
    logic           load_reg;
    logic           wb_ok_reg;
    logic           sbit_reg;
    logic           ustart_reg;
    logic           xbank_reg;
    logic           first_reg;
    logic           abort_reg;
    logic           aexc_reg;
    logic [31:0]    wb_val_reg;
    logic           pend_v_reg;
    logic [3:0]     pend_idx_reg;
    logic [31:0]    pend_data_reg;
    logic           wr_en;
    logic           wr_ubank;
    logic [3:0]     wr_idx;
    logic [31:0]    wr_data;
    logic           user_mode;
    logic           take;
    logic           acc_wr;
    logic [31:0]    merged;
    logic [3:0]     av_idx;
    logic           ack;
    logic [15:0]    rest;
    logic [3:0]     nxt_idx;
    logic [31:0]    bval;
    logic [31:0]    four_n;
    logic [31:0]    lowest;
    logic [15:0]    ilist;
    logic [3:0]     ibase;
    logic           iforce;

    assign rst_n = rst_sync_reg[1];
    assign user_mode = (r15_reg[1:0] == `MRTU_MODE_USER);
    assign take = (av_read_i || av_write_i) && av_waitrequest_o && (state_reg == ST_IDLE);
    assign acc_wr = av_write_i && !av_waitrequest_o;
    assign av_idx = av_address_i[5:2];
    assign ack = (state_reg == ST_XFER) && mem_ack_i;
    assign rest = list_reg & (list_reg - 16'h0001);
    assign nxt_idx = low_idx(rest);
    assign ilist = instr_reg[15:0];
    assign ibase = instr_reg[`MRTU_F_BASE_LO +: 4];

    // Lowest set bit of a register list
    function automatic logic [3:0] low_idx(input logic [15:0] m);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 15; i >= 0; i--) begin
            if (m[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    // Number of registers in a list
    function automatic logic [4:0] count(input logic [15:0] m);
        logic [4:0] c;
        c = 5'h00;
        for (int i = 0; i < 16; i++) begin
            c = c + {4'h0, m[i]};
        end
        return c;
    endfunction

    // Register read; index fifteen is shared by both banks
    function automatic logic [31:0] rd(input logic ub, input logic [3:0] n);
        logic [31:0] v;
        v = r15_reg;
        if (n != `MRTU_PC_IDX) begin
            v = ub ? usr_reg[n[3:0]] : prv_reg[n[3:0]];
        end
        return v;
    endfunction

    // Store value: counter carries status and runs twelve bytes ahead
    function automatic logic [31:0] st_val(input logic ub, input logic [3:0] n);
        logic [31:0] v;
        v = rd(ub, n);
        if (n == `MRTU_PC_IDX) begin
            v = {r15_reg[31:26], r15_reg[25:2] + `MRTU_PC_ADVANCE, r15_reg[1:0]};
        end
        return v;
    endfunction

    // Reset release through two flops
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end

    // Byte-lane merge of bus writes
    always_comb begin
        merged = 32'h0;
        for (int b = 0; b < 4; b++) begin
            merged[8*b +: 8] = av_byteenable_i[b] ? av_writedata_i[8*b +: 8] : 8'h00;
        end
    end

    // First address and write-back value for the four variants
    always_comb begin
        bval = rd(user_mode, ibase);
        four_n = {25'h0, count(ilist), 2'b00};
        if (instr_reg[`MRTU_F_UP]) begin
            lowest = instr_reg[`MRTU_F_PRE] ? bval + 32'h4 : bval;
        end else begin
            lowest = instr_reg[`MRTU_F_PRE] ? bval - four_n : bval - four_n + 32'h4;
        end
        iforce = instr_reg[`MRTU_F_SBIT] && !user_mode &&
                 !(instr_reg[`MRTU_F_LOAD] && ilist[15]);
    end

    // Single register-file write port; sources never coincide
    always_comb begin
        wr_en = 1'b0;
        wr_ubank = xbank_reg;
        wr_idx = base_reg;
        wr_data = wb_val_reg;
        if (state_reg == ST_IDLE) begin
            if (acc_wr && av_address_i[7:6] == `MRTU_REGION_CUR) begin
                wr_en = 1'b1;
                wr_ubank = user_mode;
                wr_idx = av_idx;
                wr_data = merged;
            end else if (acc_wr && av_address_i[7:6] == `MRTU_REGION_USR) begin
                wr_en = 1'b1;
                wr_ubank = 1'b1;
                wr_idx = av_idx;
                wr_data = merged;
            end
        end else if (ack && first_reg) begin
            wr_en = wb_ok_reg;
        end else if (ack && pend_v_reg && !abort_input_i) begin
            wr_en = 1'b1;
            wr_idx = pend_idx_reg;
            wr_data = pend_data_reg;
        end else if (state_reg == ST_DONE) begin
            if (abort_reg) begin
                wr_en = load_reg && wb_ok_reg;
            end else if (pend_v_reg) begin
                wr_en = 1'b1;
                wr_idx = pend_idx_reg;
                wr_data = pend_data_reg;
            end
        end
    end

    // Banked registers, one pair per entry
    for (genvar g = 0; g < 15; g++) begin : g_rf
        always_ff @(posedge clk_i or negedge rst_n) begin
            if (!rst_n) begin
                usr_reg[g] <= 32'h0;
                prv_reg[g] <= 32'h0;
            end else if (wr_en && wr_idx == 4'(g)) begin
                if (wr_ubank) begin
                    usr_reg[g] <= wr_data;
                end else begin
                    prv_reg[g] <= wr_data;
                end
            end
        end
    end

    // Counter and status word; loads merge per S and starting mode
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            r15_reg <= `MRTU_R15_RESET;
        end else if (wr_en && wr_idx == `MRTU_PC_IDX) begin
            if (state_reg == ST_IDLE || (wb_ok_reg && wr_data == wb_val_reg && !pend_v_reg)) begin
                r15_reg <= wr_data;
            end else if (!sbit_reg) begin
                r15_reg <= {r15_reg[31:26], wr_data[25:2], r15_reg[1:0]};
            end else if (ustart_reg) begin
                r15_reg <= {wr_data[31:28], r15_reg[27:26], wr_data[25:2], r15_reg[1:0]};
            end else begin
                r15_reg <= wr_data;
            end
        end
    end

    // Bus slave: one wait cycle once the sequencer is idle, then answer for one cycle
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            av_waitrequest_o <= 1'b1;
            av_readdata_o <= 32'h0;
        end else begin
            av_waitrequest_o <= !take;
            if (take) begin
                if (av_address_i == `MRTU_OFS_INSTR) begin
                    av_readdata_o <= instr_reg;
                end else if (av_address_i == `MRTU_OFS_STATUS) begin
                    av_readdata_o <= {29'h0, status_reg};
                end else if (av_address_i[7:6] == `MRTU_REGION_CUR) begin
                    av_readdata_o <= rd(user_mode, av_idx);
                end else if (av_address_i[7:6] == `MRTU_REGION_USR) begin
                    av_readdata_o <= rd(1'b1, av_idx);
                end else begin
                    av_readdata_o <= 32'h0;
                end
            end
        end
    end

    // Instruction word and status; trap flags set in DONE only, while busy
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            instr_reg <= 32'h0;
            status_reg <= 3'h0;
        end else begin
            status_reg[`MRTU_ST_BUSY] <= (state_reg != ST_IDLE) ||
                (acc_wr && av_address_i == `MRTU_OFS_INSTR);
            if (state_reg == ST_IDLE && acc_wr && av_address_i == `MRTU_OFS_INSTR) begin
                instr_reg <= merged;
                status_reg[2:1] <= 2'h0;
            end else if (state_reg == ST_IDLE && acc_wr && av_address_i == `MRTU_OFS_STATUS) begin
                status_reg[2:1] <= status_reg[2:1] & ~merged[2:1];
            end else if (state_reg == ST_DONE) begin
                status_reg[`MRTU_ST_AEXC] <= aexc_reg;
                status_reg[`MRTU_ST_DABT] <= abort_reg && !aexc_reg;
            end
        end
    end

    // Transfer sequencer
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            list_reg <= 16'h0;
            cur_reg <= 4'h0;
            base_reg <= 4'h0;
            load_reg <= 1'b0;
            wb_ok_reg <= 1'b0;
            sbit_reg <= 1'b0;
            ustart_reg <= 1'b0;
            xbank_reg <= 1'b0;
            first_reg <= 1'b0;
            abort_reg <= 1'b0;
            aexc_reg <= 1'b0;
            wb_val_reg <= 32'h0;
            pend_v_reg <= 1'b0;
            pend_idx_reg <= 4'h0;
            pend_data_reg <= 32'h0;
            mem_req_o <= 1'b0;
            mem_we_o <= 1'b0;
            mem_addr_o <= 26'h0;
            mem_wdata_o <= 32'h0;
            addr_exc_trap_o <= 1'b0;
            data_abort_trap_o <= 1'b0;
        end else begin
            addr_exc_trap_o <= 1'b0;
            data_abort_trap_o <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (acc_wr && av_address_i == `MRTU_OFS_INSTR) begin
                        state_reg <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    // First instruction cycle: latch the decoded instruction
                    list_reg <= ilist;
                    cur_reg <= low_idx(ilist);
                    base_reg <= ibase;
                    load_reg <= instr_reg[`MRTU_F_LOAD];
                    wb_ok_reg <= instr_reg[`MRTU_F_WBACK] && ibase != `MRTU_PC_IDX;
                    sbit_reg <= instr_reg[`MRTU_F_SBIT];
                    ustart_reg <= user_mode;
                    xbank_reg <= user_mode || iforce;
                    wb_val_reg <= instr_reg[`MRTU_F_UP] ? bval + four_n : bval - four_n;
                    aexc_reg <= |lowest[`MRTU_ADDR_CHK_HI:`MRTU_ADDR_CHK_LO];
                    abort_reg <= |lowest[`MRTU_ADDR_CHK_HI:`MRTU_ADDR_CHK_LO];
                    first_reg <= 1'b1;
                    pend_v_reg <= 1'b0;
                    mem_addr_o <= {lowest[25:2], r15_reg[1:0]};
                    mem_wdata_o <= st_val(user_mode || iforce, low_idx(ilist));
                    mem_we_o <= !instr_reg[`MRTU_F_LOAD] &&
                                !(|lowest[`MRTU_ADDR_CHK_HI:`MRTU_ADDR_CHK_LO]);
                    mem_req_o <= ilist != 16'h0;
                    state_reg <= (ilist != 16'h0) ? ST_XFER : ST_DONE;
                end
                ST_XFER: begin
                    if (mem_ack_i) begin
                        first_reg <= 1'b0;
                        if (abort_input_i) begin
                            abort_reg <= 1'b1;
                            pend_v_reg <= 1'b0;
                        end else if (load_reg && !abort_reg) begin
                            pend_v_reg <= 1'b1;
                            pend_idx_reg <= cur_reg;
                            pend_data_reg <= mem_rdata_i;
                        end
                        // Next word wraps inside 26 bits, no further check
                        mem_addr_o[25:2] <= mem_addr_o[25:2] + 24'h00_0001;
                        cur_reg <= nxt_idx;
                        list_reg <= rest;
                        // A base stored after write-back shows the new value
                        if (first_reg && wb_ok_reg && nxt_idx == base_reg) begin
                            mem_wdata_o <= wb_val_reg;
                        end else begin
                            mem_wdata_o <= st_val(xbank_reg, nxt_idx);
                        end
                        if (rest == 16'h0) begin
                            mem_req_o <= 1'b0;
                            mem_we_o <= 1'b0;
                            state_reg <= ST_DONE;
                        end
                    end
                end
                ST_DONE: begin
                    // Traps only after the whole instruction has run
                    addr_exc_trap_o <= aexc_reg;
                    data_abort_trap_o <= abort_reg && !aexc_reg;
                    pend_v_reg <= 1'b0;
                    state_reg <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n);

    property p_no_store_aexc;
        state_reg == ST_XFER && aexc_reg |-> !mem_we_o;
    endproperty
    a_no_store_aexc: assert property (p_no_store_aexc) else $error("store after bad address");

    property p_aexc_trap;
        state_reg == ST_DONE && aexc_reg |=> addr_exc_trap_o && !data_abort_trap_o;
    endproperty
    a_aexc_trap: assert property (p_aexc_trap) else $error("address trap missing");

    property p_mode_bits;
        mem_req_o |-> mem_addr_o[1:0] == r15_reg[1:0];
    endproperty
    a_mode_bits: assert property (p_mode_bits) else $error("mode bits wrong");

    property p_addr_step;
        ack && rest != 16'h0 |=> mem_addr_o[25:2] == $past(mem_addr_o[25:2]) + 24'h00_0001;
    endproperty
    a_addr_step: assert property (p_addr_step) else $error("address not ascending");

    property p_abort_trap;
        state_reg == ST_DONE && abort_reg && !aexc_reg |=> data_abort_trap_o;
    endproperty
    a_abort_trap: assert property (p_abort_trap) else $error("abort trap missing");

    property p_no_load_after_abort;
        state_reg == ST_XFER && load_reg && abort_reg |->
            !wr_en || (first_reg && wr_idx == base_reg && wr_data == wb_val_reg);
    endproperty
    a_no_load_after_abort: assert property (p_no_load_after_abort) else $error("load after abort");

    property p_req_hold;
        mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_wdata_o);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("request dropped");

    property p_base15_nowb;
        state_reg == ST_XFER && base_reg == `MRTU_PC_IDX |-> !wb_ok_reg;
    endproperty
    a_base15_nowb: assert property (p_base15_nowb) else $error("counter written back");

    property p_wb_first;
        ack && first_reg && wb_ok_reg |-> wr_en && wr_idx == base_reg && wr_data == wb_val_reg;
    endproperty
    a_wb_first: assert property (p_wb_first) else $error("write-back missed");

    c_store: cover property (state_reg == ST_DONE && !load_reg && !abort_reg);
    c_load_abort: cover property (state_reg == ST_DONE && load_reg && abort_reg && !aexc_reg);
    c_aexc: cover property (addr_exc_trap_o);
endmodule

// [verification/mrtu_mem_model.sv]
// Memory system and memory manager model for the transfer unit's memory port.
// Assumes one transfer pending at a time on clk_i; ack and abort are registered.
`timescale 1ns/1ps
module mrtu_mem_model (
    input  wire logic        clk_i,       // Clock
    input  wire logic        mem_req_i,   // Transfer pending
    input  wire logic        mem_we_i,    // Store when high
    input  wire logic [25:0] mem_addr_i,  // Word address and mode
    input  wire logic [31:0] mem_wdata_i, // Store data
    input  wire logic [1:0]  delay_i,     // Wait cycles per transfer
    input  wire logic [7:0]  abort_at_i,  // Transfer number to abort, 0 none
    output logic      [31:0] mem_rdata_o, // Load data
    output logic             mem_ack_o,   // Transfer done
    output logic             abort_o      // Abort with ack
);
    logic [31:0] mem [int];
    logic [7:0]  cnt_reg;
    logic [1:0]  wait_reg;
    // Answer after delay_i cycles; data bus toggles when idle so no stale value lingers
    always @(posedge clk_i) begin
        mem_ack_o   <= 1'b0;
        abort_o     <= 1'b0;
        mem_rdata_o <= ~mem_rdata_o;
        if (!mem_req_i) begin
            cnt_reg  <= 8'h00;
            wait_reg <= 2'h0;
        end else if (!mem_ack_o && wait_reg >= delay_i) begin
            mem_ack_o <= 1'b1;
            abort_o   <= (cnt_reg + 8'h01 == abort_at_i);
            if (mem_we_i && cnt_reg + 8'h01 != abort_at_i) begin
                mem[int'(mem_addr_i[25:2])] = mem_wdata_i;
            end
            mem_rdata_o <= mem.exists(int'(mem_addr_i[25:2])) ?
                           mem[int'(mem_addr_i[25:2])] : {8'h5a, mem_addr_i[25:2]};
            cnt_reg  <= cnt_reg + 8'h01;
            wait_reg <= 2'h0;
        end else if (!mem_ack_o) begin
            wait_reg <= wait_reg + 2'h1;
        end
    end
endmodule

// [verification/mrtu_top_tb.sv]
// Self-checking bench for the multi-register transfer unit.
// Assumes registers via Avalon-MM and the memory model on the far side.
`timescale 1ns/1ps
module mrtu_top_tb;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        av_read = 1'b0;
    logic        av_write = 1'b0;
    logic [7:0]  av_addr = 8'h00;
    logic [31:0] av_wdata = 32'h0;
    logic [1:0]  dly = 2'h0;
    logic [7:0]  ab_at = 8'h00;
    logic [31:0] av_rdata, wdat, rdat, q;
    logic        av_wait, req, we, ack, abt, aexc, dabt, seen_a, seen_d;
    logic [25:0] addr;
    logic [31:0] rm [16];
    logic [31:0] qa [$], qd [$], qr [$];
    logic        qw [$];
    int          error_cnt = 0, checks_done = 0, seed = 3200;
    initial forever #2 clk = ~clk;
    mrtu_top mrtu_top_inst (.clk_i(clk), .rst_n_i(rst_n), .av_address_i(av_addr),
        .av_read_i(av_read), .av_write_i(av_write), .av_writedata_i(av_wdata),
        .av_byteenable_i(4'hf), .av_readdata_o(av_rdata), .av_waitrequest_o(av_wait),
        .mem_req_o(req), .mem_we_o(we), .mem_addr_o(addr), .mem_wdata_o(wdat),
        .mem_rdata_i(rdat), .mem_ack_i(ack), .abort_input_i(abt),
        .addr_exc_trap_o(aexc), .data_abort_trap_o(dabt));
    mrtu_mem_model mrtu_mem_model_inst (.clk_i(clk), .mem_req_i(req), .mem_we_i(we),
        .mem_addr_i(addr), .mem_wdata_i(wdat), .delay_i(dly), .abort_at_i(ab_at),
        .mem_rdata_o(rdat), .mem_ack_o(ack), .abort_o(abt));
    // Log every completed transfer and trap pulse as seen on the pins
    always @(posedge clk) begin
        if (req && ack) begin
            qa.push_back({6'h0, addr});
            qw.push_back(we);
            qd.push_back(wdat);
            qr.push_back(rdat);
        end
        if (aexc) seen_a = 1'b1;
        if (dabt) seen_d = 1'b1;
    end
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Hold the request until waitrequest is sampled low, then release
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        av_addr  <= a;
        av_wdata <= d;
        av_write <= wr;
        av_read  <= !wr;
        @(posedge clk);
        while (av_wait !== 1'b0 && n < 500) begin
            @(posedge clk);
            n++;
        end
        if (av_wait !== 1'b0) error_cnt++;
        q = av_rdata;
        av_write <= 1'b0;
        av_read  <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wreg(input int n, input logic [31:0] v);
        bus(1'b1, 8'h40 + 8'(4 * n), v);
        rm[n] = v;
    endtask
    // One instruction, checked transfer by transfer against the reference bank
    task automatic run(input logic ld, pre, up, wb, input logic [3:0] rn,
                       input logic [15:0] l, input int ab);
        logic [31:0] b, nb, f, e;
        logic        aex;
        int          k, p, n;
        k = $countones(l);
        b = rm[rn];
        nb = up ? b + 32'(4 * k) : b - 32'(4 * k);
        f = up ? (pre ? b + 32'h4 : b) : (pre ? nb : nb + 32'h4);
        aex = |f[31:26];
        qa.delete();
        qw.delete();
        qd.delete();
        qr.delete();
        seen_a = 1'b0;
        seen_d = 1'b0;
        ab_at <= 8'(ab);
        dly <= 2'($random(seed));
        bus(1'b1, 8'h00, {7'h0, pre, up, 1'b0, wb, ld, rn, l});
        n = 0;
        do begin
            bus(1'b0, 8'h04, 32'h0);
            n++;
        end while (q[0] !== 1'b0 && n < 100);
        if (q[0] !== 1'b0) error_cnt++;
        repeat (4) @(posedge clk);
        chk("status", {29'h0, ab != 0 && !aex, aex, 1'b0}, q);
        chk("addr trap", 32'(aex), 32'(seen_a));
        chk("abort trap", 32'(ab != 0 && !aex), 32'(seen_d));
        chk("count", 32'(k), 32'(qa.size()));
        p = 0;
        for (n = 0; n < 16; n++) begin
            if (l[n]) begin
                e = f + 32'(4 * p);
                chk("addr", {6'h0, e[25:2], 2'b11}, qa[p]);
                chk("we", 32'(!ld && !aex), 32'(qw[p]));
                e = (n == rn && wb && p > 0) ? nb : rm[n];
                if (n == 15) e[25:2] = e[25:2] + 24'h3;
                if (!ld && !aex) chk("data", e, qd[p]);
                if (ld && !aex && (ab == 0 || p + 1 < ab - 1)) rm[n] = qr[p];
                p++;
            end
        end
        if (wb && !(ld && ab == 0 && !aex && l[rn])) rm[rn] = nb;
        for (n = 0; n < 16; n++) begin
            bus(1'b0, 8'h40 + 8'(4 * n), 32'h0);
            chk("reg", rm[n], q);
        end
        bus(1'b1, 8'h04, 32'h6);
        $display("test done ld=%0b pre=%0b up=%0b wb=%0b abort=%0d", ld, pre, up, wb, ab);
    endtask
    initial begin
        logic [15:0] l;
        int          i, ab;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        bus(1'b0, 8'h7c, 32'h0);
        chk("r15 reset", 32'h0c00_0003, q);
        bus(1'b1, 8'hfc, 32'hffff_ffff);
        bus(1'b0, 8'hfc, 32'h0);
        chk("unmapped", 32'h0, q);
        for (i = 0; i < 15; i++) wreg(i, 32'h0100_0000 | (32'($random(seed)) & 32'h000f_fffc));
        rm[15] = 32'h0c00_0003;
        // All four variants, store and load, with and without write-back and aborts
        for (i = 0; i < 16; i++) begin
            l = 16'($random(seed)) | 16'h0111;
            if (i[3]) l[15] = 1'b0;
            ab = (i % 3 == 2) ? 1 + int'({$random(seed)} % 3) : 0;
            run(i[3], i[0], i[1], i[2], 4'({$random(seed)} % 15), l, ab);
        end
        // Illegal first address: stores suppressed, loads discarded
        wreg(3, 32'h0400_0010);
        run(1'b0, 1'b0, 1'b1, 1'b0, 4'h3, 16'h00f0, 0);
        run(1'b1, 1'b1, 1'b1, 1'b0, 4'h3, 16'h00f0, 0);
        // Forced user bank: store takes user r1, load fills user r2, then a counter load
        wreg(3, 32'h0000_2000);
        bus(1'b1, 8'h84, 32'h0000_1110);
        qd.delete();
        bus(1'b1, 8'h00, {7'h0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 4'h3, 16'h0002});
        bus(1'b0, 8'h84, 32'h0);
        chk("user store", 32'h0000_1110, qd[0]);
        bus(1'b1, 8'h00, {7'h0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 4'h3, 16'h0004});
        bus(1'b0, 8'h88, 32'h0);
        chk("user load", 32'h0000_1110, q);
        bus(1'b0, 8'h48, 32'h0);
        chk("cur kept", rm[2], q);
        bus(1'b1, 8'h00, {7'h0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 4'h3, 16'h8000});
        bus(1'b0, 8'h7c, 32'h0);
        chk("pc load", 32'h0c00_1113, q);
        $display("test done user bank and counter load");
        report_and_stop();
    end
    // Watchdog well beyond the few thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        report_and_stop();
    end
endmodule
